/* pkg/lbz_pkg.sv */
// constants and types for the led bank brightness and zone select block
package lbz_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_SINK_BANK_ASSIGN = 8'h10;
  localparam logic [7:0] ADDR_BANK_ENABLE = 8'h11;
  localparam logic [7:0] ADDR_LIGHT_CFG = 8'h12;
  localparam logic [7:0] ADDR_LIGHT_ONE_RES = 8'h13;
  localparam logic [7:0] ADDR_LIGHT_TWO_RES = 8'h14;
  localparam logic [7:0] ADDR_ZONE_STATUS = 8'h15;
  localparam logic [7:0] ADDR_BRIGHTNESS_BASE = 8'h20;
  localparam logic [7:0] ADDR_DIMMING_BASE = 8'h24;
  localparam logic [7:0] ADDR_BND_HIGH_BASE = 8'h30;
  localparam logic [7:0] ADDR_BND_LOW_BASE = 8'h38;
  localparam logic [7:0] ADDR_TARGET_BASE = 8'h40;
  localparam logic [7:0] TARGET_BANK_STRIDE = 8'h08;
  // field positions
  localparam int LIGHT_EN_BIT = 3;
  localparam int AMBIENT_MODE_BIT = 0;
  localparam int TARGET_SEL_LSB = 2;
  localparam int DIM_SEL_BIT = 0;
  localparam int DIM_EN_LSB = 2;
  // counts
  localparam int NUM_BANKS = 3;
  localparam int NUM_SINKS = 3;
  localparam int NUM_ZONES = 5;
  localparam int NUM_BOUNDS = 4;
  localparam logic [10:0] CURRENT_STEP_UA = 11'h036;
  // reset values
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] BND_HIGH_RST = 8'hFF;
  localparam logic [7:0] BND_LOW_RST = 8'hFF;
  localparam logic [4:0] RES_RST = 5'h00;
  localparam logic [1:0] BANK_NONE = 2'h3;

  typedef enum logic [2:0] {
    LBZ_ZONE0 = 3'h0,
    LBZ_ZONE1 = 3'h1,
    LBZ_ZONE2 = 3'h3,
    LBZ_ZONE3 = 3'h2,
    LBZ_ZONE4 = 3'h6
  } lbz_zone_t;

  typedef struct packed {
    logic enable;
    logic dim;
    logic [7:0] level;
  } lbz_sink_drive_t;

  typedef struct packed {
    logic hiz;
    logic [4:0] res_code;
    logic [10:0] limit_ua;
  } lbz_light_pin_t;
endpackage

/* logic/lbz_zone_tracker.sv */
// ambient zone tracker with high/low hysteresis on shared boundaries
`timescale 1ns/100ps
module lbz_zone_tracker (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // control and sensor
  input wire logic i_enable,
  input wire logic [7:0] i_light_code,
  input wire logic [3:0][7:0] i_bnd_high,
  input wire logic [3:0][7:0] i_bnd_low,
  // zone
  output logic [2:0] o_zone
);
  lbz_pkg::lbz_zone_t state_r;
  lbz_pkg::lbz_zone_t state_nxt;
  logic [2:0] idx;

  function automatic logic [2:0] zone_index(input lbz_pkg::lbz_zone_t z);
    case (z)
      lbz_pkg::LBZ_ZONE0: zone_index = 3'h0;
      lbz_pkg::LBZ_ZONE1: zone_index = 3'h1;
      lbz_pkg::LBZ_ZONE2: zone_index = 3'h2;
      lbz_pkg::LBZ_ZONE3: zone_index = 3'h3;
      lbz_pkg::LBZ_ZONE4: zone_index = 3'h4;
      default: zone_index = 3'h0;
    endcase
  endfunction

  assign idx = zone_index(state_r);

  // one zone step per cycle; up past high threshold, down below low
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      lbz_pkg::LBZ_ZONE0: begin
        if (i_light_code > i_bnd_high[0]) state_nxt = lbz_pkg::LBZ_ZONE1;
      end
      lbz_pkg::LBZ_ZONE1: begin
        if (i_light_code > i_bnd_high[1]) state_nxt = lbz_pkg::LBZ_ZONE2;
        else if (i_light_code < i_bnd_low[0]) state_nxt = lbz_pkg::LBZ_ZONE0;
      end
      lbz_pkg::LBZ_ZONE2: begin
        if (i_light_code > i_bnd_high[2]) state_nxt = lbz_pkg::LBZ_ZONE3;
        else if (i_light_code < i_bnd_low[1]) state_nxt = lbz_pkg::LBZ_ZONE1;
      end
      lbz_pkg::LBZ_ZONE3: begin
        if (i_light_code > i_bnd_high[3]) state_nxt = lbz_pkg::LBZ_ZONE4;
        else if (i_light_code < i_bnd_low[2]) state_nxt = lbz_pkg::LBZ_ZONE2;
      end
      lbz_pkg::LBZ_ZONE4: begin
        if (i_light_code < i_bnd_low[3]) state_nxt = lbz_pkg::LBZ_ZONE3;
      end
      default: state_nxt = lbz_pkg::LBZ_ZONE0;
    endcase
    // disabled interface restarts from zone 0
    if (!i_enable) state_nxt = lbz_pkg::LBZ_ZONE0;
  end

  // five zones from four boundaries
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= lbz_pkg::LBZ_ZONE0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_zone = idx;
endmodule

/* logic/lbz_bank_ctrl.sv */
// register file, bank routing, dimming gate and light pin control
`timescale 1ns/100ps
// Contract
// - each sink has a two-bit bank field; 00 ties it to bank A
// - brightness select 000..011 picks targets 0..3, top bit set picks 4
// - host mode: dim input applies only if selected target's enable bit set
// - ambient mode sets current from light input value, 0 to 2 V range
// - each light input has 32 resistor codes from its own register
// - each resistor code step adds 54 uA permitted sensor current
// - light interface disabled puts both light inputs in high impedance
// - resistor code 00000 puts that light input in high impedance
// - four shared boundaries divide the range into five zones
// - each bank has five zone targets; zone change moves to new target
// - boundaries are eight-bit thresholds over 2 V, about 7.8 mV per count
// - each boundary has high and low thresholds giving hysteresis
// - ambient mode: dimming bits 6..2 enable dim input per zone
// - dimming bit 0 picks first or second dim input per bank
// - sinks drive only when their bank enable bit is set; bit 0 is bank A
module lbz_bank_ctrl (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // register port from the serial front end
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // dimming inputs and digitized light value
  input wire logic i_dim_input_one,
  input wire logic i_dim_input_two,
  input wire logic [7:0] i_light_code,
  // sink drive
  output lbz_pkg::lbz_sink_drive_t o_sink_one_current,
  output lbz_pkg::lbz_sink_drive_t o_sink_two_current,
  output lbz_pkg::lbz_sink_drive_t o_sink_three_current,
  // light pin control
  output lbz_pkg::lbz_light_pin_t o_light_input_one,
  output lbz_pkg::lbz_light_pin_t o_light_input_two,
  output logic [2:0] o_zone
);
  logic [7:0] sink_bank_assign_r;
  logic [7:0] bank_enable_r;
  logic [7:0] light_cfg_r;
  logic [4:0] light_one_res_r;
  logic [4:0] light_two_res_r;
  logic [7:0] brightness_cfg_r [lbz_pkg::NUM_BANKS];
  logic [7:0] dimming_cfg_r [lbz_pkg::NUM_BANKS];
  logic [3:0][7:0] bnd_high_r;
  logic [3:0][7:0] bnd_low_r;
  logic [7:0] target_r [lbz_pkg::NUM_BANKS][lbz_pkg::NUM_ZONES];
  logic [7:0] rdata_nxt;
  logic light_en;
  logic [2:0] zone;
  lbz_pkg::lbz_sink_drive_t drive_nxt [lbz_pkg::NUM_SINKS];
  lbz_pkg::lbz_sink_drive_t drive_r [lbz_pkg::NUM_SINKS];

  // brightness code to target index
  function automatic logic [2:0] target_sel(input logic [2:0] code);
    target_sel = code[2] ? 3'h4 : {1'b0, code[1:0]};
  endfunction

  // resistor code to permitted sensor current in uA
  function automatic logic [10:0] current_limit(input logic [4:0] code);
    current_limit = 11'({6'h00, code} * lbz_pkg::CURRENT_STEP_UA);
  endfunction

  // light pin state from enable and code
  function automatic lbz_pkg::lbz_light_pin_t light_pin(input logic en, input logic [4:0] code);
    light_pin.hiz = !en || (code == 5'h00);
    light_pin.res_code = code;
    light_pin.limit_ua = current_limit(code);
  endfunction

  assign light_en = light_cfg_r[lbz_pkg::LIGHT_EN_BIT];

  // register writes
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sink_bank_assign_r <= lbz_pkg::REG_RST;
      bank_enable_r <= lbz_pkg::REG_RST;
      light_cfg_r <= lbz_pkg::REG_RST;
      light_one_res_r <= lbz_pkg::RES_RST;
      light_two_res_r <= lbz_pkg::RES_RST;
      for (int b = 0; b < lbz_pkg::NUM_BANKS; b++) begin
        brightness_cfg_r[b] <= lbz_pkg::REG_RST;
        dimming_cfg_r[b] <= lbz_pkg::REG_RST;
        for (int z = 0; z < lbz_pkg::NUM_ZONES; z++) begin
          target_r[b][z] <= lbz_pkg::REG_RST;
        end
      end
      for (int k = 0; k < lbz_pkg::NUM_BOUNDS; k++) begin
        bnd_high_r[k] <= lbz_pkg::BND_HIGH_RST;
        bnd_low_r[k] <= lbz_pkg::BND_LOW_RST;
      end
    end else if (i_reg_wr) begin
      if (i_reg_addr == lbz_pkg::ADDR_SINK_BANK_ASSIGN) sink_bank_assign_r <= i_reg_wdata;
      if (i_reg_addr == lbz_pkg::ADDR_BANK_ENABLE) bank_enable_r <= i_reg_wdata;
      if (i_reg_addr == lbz_pkg::ADDR_LIGHT_CFG) light_cfg_r <= i_reg_wdata;
      if (i_reg_addr == lbz_pkg::ADDR_LIGHT_ONE_RES) light_one_res_r <= i_reg_wdata[4:0];
      if (i_reg_addr == lbz_pkg::ADDR_LIGHT_TWO_RES) light_two_res_r <= i_reg_wdata[4:0];
      for (int b = 0; b < lbz_pkg::NUM_BANKS; b++) begin
        if (i_reg_addr == lbz_pkg::ADDR_BRIGHTNESS_BASE + 8'(b)) brightness_cfg_r[b] <= i_reg_wdata;
        if (i_reg_addr == lbz_pkg::ADDR_DIMMING_BASE + 8'(b)) dimming_cfg_r[b] <= i_reg_wdata;
        for (int z = 0; z < lbz_pkg::NUM_ZONES; z++) begin
          if (i_reg_addr == 8'(lbz_pkg::ADDR_TARGET_BASE + lbz_pkg::TARGET_BANK_STRIDE * 8'(b) + 8'(z))) begin
            target_r[b][z] <= i_reg_wdata;
          end
        end
      end
      // shared threshold pairs, eight bits over the 2 V span
      for (int k = 0; k < lbz_pkg::NUM_BOUNDS; k++) begin
        if (i_reg_addr == lbz_pkg::ADDR_BND_HIGH_BASE + 8'(k)) bnd_high_r[k] <= i_reg_wdata;
        if (i_reg_addr == lbz_pkg::ADDR_BND_LOW_BASE + 8'(k)) bnd_low_r[k] <= i_reg_wdata;
      end
    end
  end

  // register reads; unmapped addresses return zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (i_reg_addr == lbz_pkg::ADDR_SINK_BANK_ASSIGN) rdata_nxt = sink_bank_assign_r;
    if (i_reg_addr == lbz_pkg::ADDR_BANK_ENABLE) rdata_nxt = bank_enable_r;
    if (i_reg_addr == lbz_pkg::ADDR_LIGHT_CFG) rdata_nxt = light_cfg_r;
    if (i_reg_addr == lbz_pkg::ADDR_LIGHT_ONE_RES) rdata_nxt = {3'h0, light_one_res_r};
    if (i_reg_addr == lbz_pkg::ADDR_LIGHT_TWO_RES) rdata_nxt = {3'h0, light_two_res_r};
    if (i_reg_addr == lbz_pkg::ADDR_ZONE_STATUS) rdata_nxt = {5'h00, zone};
    for (int b = 0; b < lbz_pkg::NUM_BANKS; b++) begin
      if (i_reg_addr == lbz_pkg::ADDR_BRIGHTNESS_BASE + 8'(b)) rdata_nxt = brightness_cfg_r[b];
      if (i_reg_addr == lbz_pkg::ADDR_DIMMING_BASE + 8'(b)) rdata_nxt = dimming_cfg_r[b];
      for (int z = 0; z < lbz_pkg::NUM_ZONES; z++) begin
        if (i_reg_addr == 8'(lbz_pkg::ADDR_TARGET_BASE + lbz_pkg::TARGET_BANK_STRIDE * 8'(b) + 8'(z))) begin
          rdata_nxt = target_r[b][z];
        end
      end
    end
    for (int k = 0; k < lbz_pkg::NUM_BOUNDS; k++) begin
      if (i_reg_addr == lbz_pkg::ADDR_BND_HIGH_BASE + 8'(k)) rdata_nxt = bnd_high_r[k];
      if (i_reg_addr == lbz_pkg::ADDR_BND_LOW_BASE + 8'(k)) rdata_nxt = bnd_low_r[k];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 8'h00;
    end else begin
      o_reg_rdata <= rdata_nxt;
    end
  end

  // zone tracking runs only while the light interface is enabled
  lbz_zone_tracker u_zone (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_enable(light_en),
    .i_light_code(i_light_code),
    .i_bnd_high(bnd_high_r),
    .i_bnd_low(bnd_low_r),
    .o_zone(zone)
  );

  // per sink: bank lookup, active target, dimming gate
  always_comb begin
    logic [1:0] bank;
    logic [2:0] sel;
    logic ambient;
    logic dim_src;
    bank = 2'h0;
    sel = 3'h0;
    ambient = 1'b0;
    dim_src = 1'b0;
    for (int s = 0; s < lbz_pkg::NUM_SINKS; s++) begin
      bank = sink_bank_assign_r[2 * s +: 2];
      drive_nxt[s] = '0;
      // field value 11 leaves the sink fully off
      if (bank != lbz_pkg::BANK_NONE) begin
        ambient = brightness_cfg_r[bank][lbz_pkg::AMBIENT_MODE_BIT] && light_en;
        // ambient mode follows the tracked zone's target
        sel = ambient ? zone : target_sel(brightness_cfg_r[bank][lbz_pkg::TARGET_SEL_LSB +: 3]);
        dim_src = dimming_cfg_r[bank][lbz_pkg::DIM_SEL_BIT] ? i_dim_input_two : i_dim_input_one;
        drive_nxt[s].level = target_r[bank][sel];
        // enable bit per target in host mode, per zone in ambient mode
        drive_nxt[s].dim = dimming_cfg_r[bank][lbz_pkg::DIM_EN_LSB + 32'(sel)] ? dim_src : 1'b1;
        drive_nxt[s].enable = bank_enable_r[bank];
      end
    end
  end

  // registered sink outputs: a config, dim input or zone change shows one edge later
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int s = 0; s < lbz_pkg::NUM_SINKS; s++) begin
        drive_r[s] <= '0;
      end
    end else begin
      for (int s = 0; s < lbz_pkg::NUM_SINKS; s++) begin
        drive_r[s] <= drive_nxt[s];
      end
    end
  end

  // light pin state; a disabled interface releases both pins but still reports the resistor codes and limits
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_light_input_one <= '{hiz: 1'b1, res_code: 5'h00, limit_ua: 11'h000};
      o_light_input_two <= '{hiz: 1'b1, res_code: 5'h00, limit_ua: 11'h000};
    end else begin
      o_light_input_one <= light_pin(light_en, light_one_res_r);
      o_light_input_two <= light_pin(light_en, light_two_res_r);
    end
  end

  // zone output lags the tracker by one edge so it lines up with the sink outputs
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_zone <= 3'h0;
    end else begin
      o_zone <= zone;
    end
  end

  assign o_sink_one_current = drive_r[0];
  assign o_sink_two_current = drive_r[1];
  assign o_sink_three_current = drive_r[2];
endmodule

/* testbench/lbz_bank_ctrl_properties.sv */
// port assertions for the bank control block
`timescale 1ns/100ps
module lbz_bank_ctrl_chk (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // register writes
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  // block outputs
  input wire lbz_pkg::lbz_sink_drive_t o_sink_one_current,
  input wire lbz_pkg::lbz_sink_drive_t o_sink_two_current,
  input wire lbz_pkg::lbz_sink_drive_t o_sink_three_current,
  input wire lbz_pkg::lbz_light_pin_t o_light_input_one,
  input wire lbz_pkg::lbz_light_pin_t o_light_input_two,
  input wire logic [2:0] o_zone
);
  wire lbz_pkg::lbz_light_pin_t p1 = o_light_input_one;
  wire lbz_pkg::lbz_light_pin_t p2 = o_light_input_two;
  wire [29:0] snk = {o_sink_one_current, o_sink_two_current, o_sink_three_current};
  wire w_cfg = i_reg_wr && i_reg_addr == 8'h12;
  wire w_res = i_reg_wr && i_reg_addr == 8'h13;
  wire w_asg = i_reg_wr && i_reg_addr == 8'h10 && i_reg_wdata[5:0] == 6'h3F;
  wire w_off = i_reg_wr && i_reg_addr == 8'h11 && i_reg_wdata[2:0] == 3'h0;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  limit_scale_a: assert property (p1.limit_ua == 11'(p1.res_code) * lbz_pkg::CURRENT_STEP_UA)
    else $error("light limit wrong");
  zero_code_a: assert property (p2.res_code == 5'h00 |-> p2.hiz)
    else $error("zero code driven");
  light_off_a: assert property (w_cfg && !i_reg_wdata[3] |-> ##2 p1.hiz && p2.hiz)
    else $error("light not released");
  code_store_a: assert property (w_res |-> ##2 p1.res_code == $past(i_reg_wdata[4:0], 2))
    else $error("code not stored");
  zone_range_a: assert property (o_zone <= 3'h4)
    else $error("zone out of range");
  zone_step_a: assert property (!p1.hiz |-> o_zone - $past(o_zone) inside {3'h0, 3'h1, 3'h7})
    else $error("zone jumped");
  unassign_zero_a: assert property (w_asg |-> ##2 snk == 30'h0)
    else $error("unassigned sink driven");
  bank_off_a: assert property (w_off |-> ##2 !(snk[29] || snk[19] || snk[9]))
    else $error("disabled bank driven");
  off_zone_a: assert property (w_cfg && !i_reg_wdata[3] |-> ##4 o_zone == 3'h0)
    else $error("zone not cleared");
endmodule
bind lbz_bank_ctrl lbz_bank_ctrl_chk u_chk (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_reg_wr(i_reg_wr),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_sink_one_current(o_sink_one_current),
  .o_sink_two_current(o_sink_two_current), .o_sink_three_current(o_sink_three_current),
  .o_light_input_one(o_light_input_one), .o_light_input_two(o_light_input_two), .o_zone(o_zone));

/* testbench/lbz_sensor_model.sv */
// light sensor and dimming source at the far side of the block
`timescale 1ns/100ps
module lbz_sensor_model (
  // clock and commanded levels
  input wire logic i_clk_sys,
  input wire logic [7:0] i_level,
  input wire logic i_dim_one,
  input wire logic i_dim_two,
  // pin state in, levels out
  input wire lbz_pkg::lbz_light_pin_t i_pin,
  output logic [7:0] o_light_code,
  output logic o_dim_input_one,
  output logic o_dim_input_two
);
  logic [7:0] flt_r = 8'h3C;
  // a released input has no stable level
  always @(posedge i_clk_sys) flt_r <= flt_r + 8'h5B;
  assign o_light_code = i_pin.hiz ? flt_r : i_level;
  assign o_dim_input_one = i_dim_one;
  assign o_dim_input_two = i_dim_two;
endmodule

/* testbench/lbz_bank_ctrl_tb.sv */
// self-checking bench for the bank control block
`timescale 1ns/100ps
module lbz_bank_ctrl_tb;
  logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, obs_v = 1'b0, d1 = 1'b0, d2 = 1'b0, dim1, dim2;
  logic [7:0] addr = 8'h00, wdata = 8'h00, lvl = 8'h00, rdata, code;
  logic [2:0] zone;
  logic [4:0] c;
  logic [20:0] e;
  logic [20:0] exp_q[$];
  logic [31:0] r;
  int err_total = 0, checks = 0, k, m;
  lbz_pkg::lbz_sink_drive_t s1, s2, s3;
  lbz_pkg::lbz_light_pin_t p1, p2;
  string nm[7] = '{"rdata", "sink1", "sink2", "sink3", "pin1", "pin2", "zone"};
  logic [7:0] lv[11] = '{8'h2D, 8'h64, 8'h4B, 8'h41, 8'h28, 8'h50, 8'h51, 8'hFF, 8'h96, 8'h95, 8'h00};
  logic [2:0] zq[11] = '{3'h1, 3'h2, 3'h2, 3'h1, 3'h1, 3'h1, 3'h2, 3'h4, 3'h4, 3'h3, 3'h0};
  logic [7:0] ra[5] = '{8'h10, 8'h30, 8'h3B, 8'hFF, 8'h15};
  logic [7:0] rv[5] = '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00};
  logic [7:0] rw[9] = '{8'h10, 8'h11, 8'h13, 8'h14, 8'h20, 8'h24, 8'h25, 8'h40, 8'h4C};
  always #5 clk = ~clk;
  lbz_sensor_model u_snr (.i_clk_sys(clk), .i_level(lvl), .i_dim_one(d1), .i_dim_two(d2), .i_pin(p1),
    .o_light_code(code), .o_dim_input_one(dim1), .o_dim_input_two(dim2));
  lbz_bank_ctrl dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_reg_wr(reg_wr), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .i_dim_input_one(dim1), .i_dim_input_two(dim2), .i_light_code(code),
    .o_sink_one_current(s1), .o_sink_two_current(s2), .o_sink_three_current(s3), .o_light_input_one(p1),
    .o_light_input_two(p2), .o_zone(zone));
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick();
    reg_wr = 1'b1;
    addr = a;
    wdata = d;
    tick();
    reg_wr = 1'b0;
  endtask
  // note the expectation, then flag the monitor for one cycle
  task automatic ex(input logic [3:0] s, input logic [16:0] v);
    repeat (2) tick();
    exp_q.push_back({s, v});
    obs_v = 1'b1;
    tick();
    obs_v = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] v);
    addr = a;
    ex(4'h0, {9'h000, v});
  endtask
  task automatic chk(input string n, input logic [16:0] seen, input logic [16:0] expv);
    checks++;
    if (seen !== expv) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, expv, seen);
    end
  endtask
  function automatic logic [16:0] obs(input logic [3:0] s);
    case (s)
      4'h0: obs = {9'h000, rdata};
      4'h1: obs = {7'h00, s1};
      4'h2: obs = {7'h00, s2};
      4'h3: obs = {7'h00, s3};
      4'h4: obs = p1;
      4'h5: obs = p2;
      default: obs = {14'h0000, zone};
    endcase
  endfunction
  always @(negedge clk) begin
    if (obs_v) begin
      e = exp_q.pop_front();
      chk(nm[e[20:17]], obs(e[20:17]), e[16:0]);
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #300000;
    err_total++;
    summarize();
  end
  initial begin
    r = $urandom(32'hB420C5F4);
    repeat (2) @(posedge clk);
    #1;
    rst_b = 1'b1;
    ex(4'h4, 17'h10000);
    ex(4'h6, 17'h00000);
    for (int i = 0; i < 5; i++) rd(ra[i], rv[i]);
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
      r = $urandom;
      wr(rw[i], r[7:0]);
      rd(rw[i], (rw[i] == 8'h13 || rw[i] == 8'h14) ? {3'h0, r[4:0]} : r[7:0]);
    end
    wr(8'h15, 8'h5A);
    rd(8'h15, 8'h00);
    $display("test registers done");
    wr(8'h10, 8'h00);
    wr(8'h11, 8'h01);
    wr(8'h24, 8'h00);
    for (int i = 0; i < 5; i++) wr(8'h40 + 8'(i), 8'(8'h11 * (i + 1)));
    for (int i = 0; i < 8; i++) begin
      wr(8'h20, 8'(i << 2));
      ex(4'h1, {9'h003, 8'(8'h11 * (i > 3 ? 5 : i + 1))});
    end
    for (int i = 0; i < 10; i++) begin
      r = $urandom;
      d1 = r[0];
      d2 = r[1];
      k = i % 5;
      m = (i < 5) ? k : (k + 1) % 5;
      wr(8'h20, 8'(k << 2));
      wr(8'h24, 8'(1 << (m + 2)) | {7'h00, r[2]});
      ex(4'h1, {8'h01, (i < 5) ? (r[2] ? d2 : d1) : 1'b1, 8'(8'h11 * (k + 1))});
    end
    $display("test host select done");
    wr(8'h25, 8'h00);
    wr(8'h48, 8'h5A);
    wr(8'h50, 8'hA5);
    wr(8'h24, 8'h00);
    wr(8'h20, 8'h00);
    wr(8'h10, 8'h24);
    wr(8'h11, 8'h05);
    ex(4'h1, 17'h00311);
    ex(4'h2, 17'h0015A);
    ex(4'h3, 17'h003A5);
    wr(8'h10, 8'h3F);
    ex(4'h2, 17'h00000);
    wr(8'h10, 8'h00);
    wr(8'h11, 8'h00);
    ex(4'h1, 17'h00111);
    $display("test banks done");
    wr(8'h12, 8'h08);
    for (int i = 0; i < 4; i++) begin
      c = (i == 3) ? 5'h1F : (i == 2) ? 5'($urandom) : 5'(i);
      wr(8'h13, {3'h0, c});
      ex(4'h4, {c == 5'h00, c, 11'(c) * lbz_pkg::CURRENT_STEP_UA});
    end
    wr(8'h14, 8'h02);
    ex(4'h5, {1'b0, 5'h02, 11'h002 * lbz_pkg::CURRENT_STEP_UA});
    wr(8'h12, 8'h00);
    ex(4'h4, {1'b1, c, 11'(c) * lbz_pkg::CURRENT_STEP_UA});
    ex(4'h5, {1'b1, 5'h02, 11'h002 * lbz_pkg::CURRENT_STEP_UA});
    $display("test light pins done");
    for (int i = 0; i < 4; i++) begin
      wr(8'h30 + 8'(i), 8'(40 * (i + 1)));
      wr(8'h38 + 8'(i), 8'(40 * (i + 1) - 10));
    end
    for (int i = 0; i < 5; i++) wr(8'h40 + 8'(i), 8'h10 + 8'(i));
    wr(8'h12, 8'h08);
    wr(8'h13, 8'h01);
    wr(8'h24, 8'h54);
    wr(8'h20, 8'h01);
    wr(8'h11, 8'h01);
    d1 = 1'b0;
    for (int i = 0; i < 11; i++) begin
      lvl = lv[i];
      repeat (6) tick();
      ex(4'h6, {14'h0000, zq[i]});
      ex(4'h1, {8'h01, zq[i][0], 8'h10 + {5'h00, zq[i]}});
    end
    wr(8'h12, 8'h00);
    ex(4'h6, 17'h00000);
    $display("test ambient done");
    summarize();
  end
endmodule
